// ===== bert_rx_pkg.sv
package bert_rx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TAPS = 8'h04;
  localparam logic [7:0] OFS_PATTERN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ERR_CNT = 8'h10;
  localparam logic [7:0] OFS_BIT_CNT = 8'h14;

  // CTRL fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_QRSS_BIT = 1;
  localparam int CTRL_REP_BIT = 2;
  localparam int CTRL_RESYNC_DIS_BIT = 3;
  localparam int CTRL_CNT_CLR_BIT = 4;
  // TAPS fields, each holds tap position minus one
  localparam int TAPS_N_LSB = 0;
  localparam int TAPS_Y_LSB = 8;
  localparam int TAP_W = 5;

  // ----------------------------------------------------------------
  // Pattern and sync constants
  // ----------------------------------------------------------------
  localparam int GEN_W = 32;
  localparam logic [4:0] QRSS_TAP_A = 5'h10;
  localparam logic [4:0] QRSS_TAP_B = 5'h13;
  localparam int QRSS_ZERO_W = 14;
  localparam logic [4:0] SYNC_LEN_LAST = 5'h1F;
  localparam logic [5:0] WINDOW_LAST = 6'h3F;
  localparam logic [2:0] RESYNC_ERRS = 3'h6;
  localparam int ERR_CNT_W = 24;
  localparam int BIT_CNT_W = 32;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_VERIFY = 2'b01,
    ST_SYNC = 2'b10
  } sync_state_t;

  // ----------------------------------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// ===== bert_rx_sync.sv
// Contract
// [RULE_01] 32-stage register shifts stage 1 toward 32
// [RULE_02] Pseudo-random feedback XORs stages n and y
// [RULE_03] Repetitive feedback is stage n
// [RULE_04] Taps n and y programmable 1 to 32
// [RULE_05] Expected bit equals current feedback
// [RULE_06] QRSS taps 17,20; output forced on zeros
// [RULE_07] QRSS is an on/off setting
// [RULE_08] Feedback forced one when stages 1-31 zero
// [RULE_09] Sync method follows programmed pattern type
// [RULE_10] Load 32, verify 32, all match locks
// [RULE_11] Six errors per 64 bits resync PRBS
// [RULE_12] Repetitive: hunt pattern, verify 32 bits
// [RULE_13] Six errors per 64 bits resync repetitive
// [RULE_14] Repetitive length 1-32, value programmable
// [RULE_15] Only qualified payload bits are processed
// [RULE_16] Sender marks gapped bits with qualifiers
// [RULE_17] Active tester halts and overrides traffic
// [RULE_18] Normal connection restored when tester ends
// [RULE_19] 24-bit error and 32-bit bit counters
// [RULE_20] Supports 2^9-1, 2^15-1, 2^23-1, QRSS
// [RULE_21] Sync-lost flag set unless locked
// [RULE_22] Counters advance only while locked
// [RULE_23] Resync clears window, restarts next bit
// [RULE_24] Lock holds; disable returns to hunt
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module bert_rx_sync (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire bert_rx_pkg::axil_req_t axi_req_in,
  output bert_rx_pkg::axil_rsp_t axi_rsp_out,
  input wire logic rx_data_in,
  input wire logic rx_payload_qualifier_in,
  output logic fwd_data_out,
  output logic fwd_qual_out,
  output logic bert_active_out,
  output logic sync_lost_flag_out
);
  import bert_rx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sync_state_t st;
    logic [GEN_W-1:0] gen;
    logic [4:0] cnt;
    logic [5:0] win_bits;
    logic [2:0] win_errs;
    logic [ERR_CNT_W-1:0] err_cnt;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic en;
    logic qrss;
    logic rep;
    logic resync_dis;
    logic [TAP_W-1:0] n_tap;
    logic [TAP_W-1:0] y_tap;
    logic [GEN_W-1:0] pattern;
    logic d_s1;
    logic d_s2;
    logic q_s1;
    logic q_s2;
    logic fwd_data;
    logic fwd_qual;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } core_state_t;

  localparam core_state_t RESET_STATE = '0;

  core_state_t core_r;
  core_state_t core_nxt;

  // Elaboration check: counters must fit a bus word
  if (ERR_CNT_W > 32 || BIT_CNT_W > 32 || GEN_W != 32) begin : g_bad_width
    $error("Counter or generator width not supported");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Pattern generator taps
  // ----------------------------------------------------------------
  logic fb;
  logic exp_bit;
  logic [GEN_W-1:0] len_mask;
  logic [GEN_W-1:0] hunt_shift;
  logic hunt_match;
  logic rx_bit;
  logic rx_qual;
  logic mismatch;

  assign rx_bit = core_r.d_s2;
  assign rx_qual = core_r.q_s2;

  always_comb begin
    if (core_r.rep) begin
      fb = core_r.gen[core_r.n_tap]; // [RULE_03]
    end else if (core_r.qrss) begin
      fb = core_r.gen[QRSS_TAP_A] ^ core_r.gen[QRSS_TAP_B]; // [RULE_06] [RULE_07]
    end else begin
      fb = core_r.gen[core_r.n_tap] ^ core_r.gen[core_r.y_tap]; // [RULE_02] [RULE_04] [RULE_20]
    end
    // Keeps an all-zero register from locking up the sequence
    if (!core_r.rep && core_r.gen[GEN_W-2:0] == '0) begin
      fb = 1'b1; // [RULE_08]
    end
    exp_bit = fb; // [RULE_05]
    if (!core_r.rep && core_r.qrss && core_r.gen[QRSS_ZERO_W-1:0] == '0) begin
      exp_bit = 1'b1; // [RULE_06]
    end
  end

  // Length mask of n low bits; the pattern's bit n-1 is the oldest bit
  assign len_mask = {GEN_W{1'b1}} >> (5'h1F - core_r.n_tap); // [RULE_14]
  assign hunt_shift = {core_r.gen[GEN_W-2:0], rx_bit}; // [RULE_01]
  assign hunt_match = (hunt_shift & len_mask) == (core_r.pattern & len_mask); // [RULE_12]
  assign mismatch = rx_bit != exp_bit;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic wr_fire;
  logic cnt_clr;
  logic [2:0] errs_inc;
  logic [31:0] ctrl_word;
  logic [31:0] taps_word;
  logic [31:0] ctrl_new;
  logic [31:0] taps_new;
  logic [7:0] raddr;

  assign ctrl_word = {27'h0, 1'b0, core_r.resync_dis, core_r.rep, core_r.qrss, core_r.en};
  assign taps_word = {19'h0, core_r.y_tap, 3'h0, core_r.n_tap};
  assign ctrl_new = merge_bytes(ctrl_word, core_r.wdata, core_r.wstrb);
  assign taps_new = merge_bytes(taps_word, core_r.wdata, core_r.wstrb);
  assign wr_fire = core_r.aw_got && core_r.w_got && !core_r.bvalid;
  assign cnt_clr = wr_fire && core_r.awaddr == OFS_CTRL && ctrl_new[CTRL_CNT_CLR_BIT];
  assign raddr = axi_req_in.araddr[7:0];

  always_comb begin
    core_nxt = core_r;
    errs_inc = core_r.win_errs + 3'h1;

    // Pin synchronisers
    core_nxt.d_s1 = rx_data_in;
    core_nxt.d_s2 = core_r.d_s1;
    core_nxt.q_s1 = rx_payload_qualifier_in;
    core_nxt.q_s2 = core_r.q_s1;

    // While active the mapper path sees idle ones with no payload
    core_nxt.fwd_data = core_r.en ? 1'b1 : rx_bit; // [RULE_17] [RULE_18]
    core_nxt.fwd_qual = core_r.en ? 1'b0 : rx_qual; // [RULE_17] [RULE_18]

    // ---------------------------- bus write ----------------------
    if (axi_req_in.awvalid && !core_r.aw_got && !core_r.bvalid) begin
      core_nxt.aw_got = 1'b1;
      core_nxt.awaddr = axi_req_in.awaddr[7:0];
    end
    if (axi_req_in.wvalid && !core_r.w_got && !core_r.bvalid) begin
      core_nxt.w_got = 1'b1;
      core_nxt.wdata = axi_req_in.wdata;
      core_nxt.wstrb = axi_req_in.wstrb;
    end
    if (wr_fire) begin
      core_nxt.aw_got = 1'b0;
      core_nxt.w_got = 1'b0;
      core_nxt.bvalid = 1'b1;
      core_nxt.bresp = RESP_OKAY;
      unique case (core_r.awaddr)
        OFS_CTRL: begin
          core_nxt.en = ctrl_new[CTRL_EN_BIT];
          core_nxt.qrss = ctrl_new[CTRL_QRSS_BIT]; // [RULE_07]
          core_nxt.rep = ctrl_new[CTRL_REP_BIT]; // [RULE_09]
          core_nxt.resync_dis = ctrl_new[CTRL_RESYNC_DIS_BIT];
        end
        OFS_TAPS: begin
          core_nxt.n_tap = taps_new[TAPS_N_LSB +: TAP_W]; // [RULE_04]
          core_nxt.y_tap = taps_new[TAPS_Y_LSB +: TAP_W]; // [RULE_04]
        end
        OFS_PATTERN: core_nxt.pattern = merge_bytes(core_r.pattern, core_r.wdata,
                                                     core_r.wstrb); // [RULE_14]
        OFS_STATUS, OFS_ERR_CNT, OFS_BIT_CNT: core_nxt.bresp = RESP_OKAY;
        default: core_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (core_r.bvalid && axi_req_in.bready) begin
      core_nxt.bvalid = 1'b0;
    end

    // ---------------------------- bus read -----------------------
    if (core_r.rvalid && axi_req_in.rready) begin
      core_nxt.rvalid = 1'b0;
    end
    if (axi_req_in.arvalid && !core_r.rvalid) begin
      core_nxt.rvalid = 1'b1;
      core_nxt.rresp = RESP_OKAY;
      unique case (raddr)
        OFS_CTRL: core_nxt.rdata = ctrl_word;
        OFS_TAPS: core_nxt.rdata = taps_word;
        OFS_PATTERN: core_nxt.rdata = core_r.pattern;
        OFS_STATUS: core_nxt.rdata = {28'h0, core_r.en, core_r.st, core_r.st != ST_SYNC};
        OFS_ERR_CNT: core_nxt.rdata = {{(32-ERR_CNT_W){1'b0}}, core_r.err_cnt}; // [RULE_19]
        OFS_BIT_CNT: core_nxt.rdata = core_r.bit_cnt; // [RULE_19]
        default: begin
          core_nxt.rdata = 32'h0;
          core_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    // ---------------------------- sync machine -------------------
    if (!core_r.en) begin
      core_nxt.st = ST_HUNT; // [RULE_24]
      core_nxt.cnt = '0;
      core_nxt.win_bits = '0;
      core_nxt.win_errs = '0;
    end else if (rx_qual) begin // [RULE_15]
      unique case (core_r.st)
        ST_HUNT: begin
          core_nxt.gen = hunt_shift; // [RULE_01]
          if (core_r.rep) begin
            if (hunt_match) begin
              core_nxt.st = ST_VERIFY; // [RULE_12]
              core_nxt.cnt = '0;
            end
          end else begin
            core_nxt.cnt = core_r.cnt + 5'h1;
            if (core_r.cnt == SYNC_LEN_LAST) begin
              core_nxt.st = ST_VERIFY; // [RULE_10]
              core_nxt.cnt = '0;
            end
          end
        end
        ST_VERIFY: begin
          core_nxt.gen = {core_r.gen[GEN_W-2:0], fb}; // [RULE_01]
          core_nxt.cnt = core_r.cnt + 5'h1;
          if (mismatch) begin
            core_nxt.st = ST_HUNT; // [RULE_10] [RULE_12]
            core_nxt.cnt = '0;
          end else if (core_r.cnt == SYNC_LEN_LAST) begin
            core_nxt.st = ST_SYNC; // [RULE_10] [RULE_12]
            core_nxt.win_bits = '0;
            core_nxt.win_errs = '0;
          end
        end
        ST_SYNC: begin
          core_nxt.gen = {core_r.gen[GEN_W-2:0], fb}; // [RULE_01]
          core_nxt.win_bits = core_r.win_bits + 6'h1;
          if (mismatch) begin
            core_nxt.win_errs = errs_inc;
          end
          if (core_r.win_bits == WINDOW_LAST) begin
            core_nxt.win_bits = '0;
            core_nxt.win_errs = '0;
          end
          if (mismatch && errs_inc >= RESYNC_ERRS && !core_r.resync_dis) begin
            core_nxt.st = ST_HUNT; // [RULE_11] [RULE_13]
            core_nxt.cnt = '0; // [RULE_23]
            core_nxt.win_bits = '0; // [RULE_23]
            core_nxt.win_errs = '0; // [RULE_23]
          end
        end
        default: core_nxt.st = ST_HUNT;
      endcase
    end

    // Counters stop at their maximum instead of wrapping
    if (cnt_clr) begin
      core_nxt.err_cnt = '0;
      core_nxt.bit_cnt = '0;
    end else if (core_r.en && rx_qual && core_r.st == ST_SYNC) begin // [RULE_22]
      if (core_r.bit_cnt != '1) begin
        core_nxt.bit_cnt = core_r.bit_cnt + 1'b1; // [RULE_19]
      end
      if (mismatch && core_r.err_cnt != '1) begin
        core_nxt.err_cnt = core_r.err_cnt + 1'b1; // [RULE_19]
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      core_r <= RESET_STATE;
    end else if (ce_in) begin
      core_r <= core_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    axi_rsp_out.awready = !core_r.aw_got && !core_r.bvalid;
    axi_rsp_out.wready = !core_r.w_got && !core_r.bvalid;
    axi_rsp_out.bvalid = core_r.bvalid;
    axi_rsp_out.bresp = core_r.bresp;
    axi_rsp_out.arready = !core_r.rvalid;
    axi_rsp_out.rvalid = core_r.rvalid;
    axi_rsp_out.rdata = core_r.rdata;
    axi_rsp_out.rresp = core_r.rresp;
  end

  assign fwd_data_out = core_r.fwd_data;
  assign fwd_qual_out = core_r.fwd_qual;
  assign bert_active_out = core_r.en;
  assign sync_lost_flag_out = core_r.st != ST_SYNC; // [RULE_21]

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_LOAD_LEN: assert property ( // [RULE_10]
    (ce_in && core_r.en && !core_r.rep && core_r.st == ST_HUNT && rx_qual
     && core_r.cnt == SYNC_LEN_LAST) |=> core_r.st == ST_VERIFY)
    else $error("Pattern load did not end after 32 bits");

  AST_LOCK_AFTER_VERIFY: assert property ( // [RULE_10]
    $rose(core_r.st == ST_SYNC) |-> $past(core_r.st) == ST_VERIFY
      && $past(core_r.cnt) == SYNC_LEN_LAST && !$past(mismatch))
    else $error("Lock declared without 32 matching bits");

  AST_FLAG_CLEARS: assert property ( // [RULE_21]
    $fell(sync_lost_flag_out) |-> $past(core_r.st == ST_VERIFY && rx_qual))
    else $error("Sync-lost flag cleared without a verify pass");

  AST_RESYNC: assert property ( // [RULE_11]
    (ce_in && core_r.en && core_r.st == ST_SYNC && rx_qual && mismatch
     && core_r.win_errs == 3'h5 && !core_r.resync_dis)
      |=> core_r.st == ST_HUNT && core_r.win_errs == 3'h0)
    else $error("Sixth window error did not restart sync");

  AST_HOLD_LOCK: assert property ( // [RULE_24]
    (ce_in && core_r.en && core_r.resync_dis && core_r.st == ST_SYNC && !wr_fire)
      |=> core_r.st == ST_SYNC)
    else $error("Lock dropped while resync is disabled");

  AST_DISABLE: assert property ( // [RULE_24]
    (ce_in && !core_r.en) |=> core_r.st == ST_HUNT)
    else $error("Disabled tester left sync machine out of hunt");

  AST_NO_COUNT_OOS: assert property ( // [RULE_22]
    (ce_in && core_r.st != ST_SYNC && !cnt_clr) |=> $stable(core_r.bit_cnt)
      && $stable(core_r.err_cnt))
    else $error("Counter moved while out of sync");

  AST_ERR_COUNT: assert property ( // [RULE_22]
    (ce_in && core_r.en && core_r.st == ST_SYNC && rx_qual && mismatch && !cnt_clr
     && core_r.err_cnt != '1) |=> core_r.err_cnt == $past(core_r.err_cnt) + 1'b1)
    else $error("Mismatch not counted");

  AST_GAP_IGNORED: assert property ( // [RULE_15]
    (ce_in && !rx_qual && core_r.en) |=> $stable(core_r.gen) && $stable(core_r.st))
    else $error("Gapped bit was processed");

  AST_OVERRIDE: assert property ( // [RULE_17]
    (ce_in && core_r.en) |=> !fwd_qual_out ##0 fwd_data_out)
    else $error("Normal path not overridden while active");

  AST_PRBS_FB: assert property ( // [RULE_02]
    (ce_in && core_r.en && !core_r.rep && !core_r.qrss && core_r.st != ST_HUNT && rx_qual
     && core_r.gen[GEN_W-2:0] != '0)
      |=> core_r.gen == {$past(core_r.gen[GEN_W-2:0]),
                         $past(core_r.gen[core_r.n_tap] ^ core_r.gen[core_r.y_tap])})
    else $error("Pseudo-random feedback wrong");

endmodule // bert_rx_sync

`default_nettype wire

// ===== bert_rx_partner.sv
`timescale 1ns/1ps
`default_nettype none

module bert_rx_partner (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic run_in,
  input wire logic rep_in,
  input wire logic qrss_in,
  input wire logic [4:0] n_in,
  input wire logic [4:0] y_in,
  input wire logic [31:0] pat_in,
  input wire logic gap_in,
  input wire logic flip_in,
  output logic data_out,
  output logic qual_out
);
  // ------------------------------------------------------------
  // Pattern source of the framer side
  // ------------------------------------------------------------
  logic [31:0] gen_r;
  logic fb;
  logic bit_v;

  always_comb begin
    if (rep_in) begin
      fb = gen_r[n_in];
    end else if (qrss_in) begin
      fb = gen_r[16] ^ gen_r[19];
    end else begin
      fb = gen_r[n_in] ^ gen_r[y_in];
    end
    if (!rep_in && gen_r[30:0] == 31'h0) begin
      fb = 1'b1;
    end
    bit_v = fb;
    if (!rep_in && qrss_in && gen_r[13:0] == 14'h0) begin
      bit_v = 1'b1;
    end
  end

  // Gapped bit times toggle the data line so a stale value never looks valid
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gen_r <= 32'hFFFFFFFF;
      data_out <= 1'b0;
      qual_out <= 1'b0;
    end else if (!run_in || gap_in) begin
      qual_out <= 1'b0;
      data_out <= ~data_out;
      if (!run_in) begin
        gen_r <= rep_in ? pat_in : 32'hFFFFFFFF;
      end
    end else begin
      qual_out <= 1'b1;
      data_out <= bit_v ^ flip_in;
      gen_r <= {gen_r[30:0], fb};
    end
  end
endmodule // bert_rx_partner

`default_nettype wire

// ===== bert_receive_pattern_sync_bench.sv
`timescale 1ns/1ps
`default_nettype none

module bert_receive_pattern_sync_bench;
  import bert_rx_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_in, nrst_in, rx_data, rx_qual, fwd_data_out, fwd_qual_out;
  logic bert_active_out, sync_lost_flag_out;
  axil_req_t req;
  axil_rsp_t rsp;
  logic run, rep, qrss, gap, gap_en, flip;
  logic [4:0] tn, ty;
  logic [31:0] pat, lfsr_r, rd;
  logic [1:0] resp;
  logic [2:0] dly_d, dly_q;
  logic [4:0] tn_tab [4] = '{5'h08, 5'h0E, 5'h16, 5'h00};
  logic [4:0] ty_tab [4] = '{5'h04, 5'h0D, 5'h11, 5'h00};
  int len_tab [3] = '{1, 8, 32};
  int mismatches, num_checks;

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  bert_rx_sync u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .axi_req_in(req),
    .axi_rsp_out(rsp), .rx_data_in(rx_data), .rx_payload_qualifier_in(rx_qual),
    .fwd_data_out(fwd_data_out), .fwd_qual_out(fwd_qual_out),
    .bert_active_out(bert_active_out), .sync_lost_flag_out(sync_lost_flag_out));

  bert_rx_partner u_far (.clk_in(clk_in), .nrst_in(nrst_in), .run_in(run), .rep_in(rep),
    .qrss_in(qrss), .n_in(tn), .y_in(ty), .pat_in(pat), .gap_in(gap), .flip_in(flip),
    .data_out(rx_data), .qual_out(rx_qual));

  // ------------------------------------------------------------
  // Random gaps and delayed copy of the line
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  function automatic logic [31:0] status_exp(input logic lost, input logic [1:0] st,
                                             input logic en);
    return {28'h0, en, st, lost};
  endfunction

  function automatic logic [31:0] mask_of(input int len);
    return (len == 32) ? 32'hFFFFFFFF : ((32'h1 << len) - 32'h1);
  endfunction

  always @(posedge clk_in) begin
    lfsr_r <= lfsr(lfsr_r);
    gap <= gap_en & lfsr_r[5];
    dly_d <= {dly_d[1:0], rx_data};
    dly_q <= {dly_q[1:0], rx_qual};
  end

  // ------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: word got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: flag got %b expected %b", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_in);
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_in);
      if (rsp.awready === 1'b1 && !aw_done) begin
        aw_done = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready === 1'b1 && !w_done) begin
        w_done = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk_in); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    resp = rsp.bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk_in);
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk_in); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_in); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    resp = rsp.rresp;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axr(a);
    chk32(rd, e);
    chk32({30'h0, resp}, {30'h0, er});
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axw(a, d);
    chk32({30'h0, resp}, {30'h0, er});
  endtask

  // Bounded wait; a flag that never arrives shows up as a mismatch
  task automatic wait_flag(input logic v);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_in);
      #1;
      if (sync_lost_flag_out === v) break;
    end
    chk1(sync_lost_flag_out, v);
  endtask

  task automatic fwd_chk();
    repeat (4) @(posedge clk_in);
    repeat (16) begin
      @(posedge clk_in);
      #1;
      chk1(fwd_data_out, dly_d[2]);
      chk1(fwd_qual_out, dly_q[2]);
    end
  endtask

  task automatic flip_bits(input int n);
    @(posedge clk_in);
    flip <= 1'b1;
    repeat (n) @(posedge clk_in);
    flip <= 1'b0;
  endtask

  task automatic start(input logic [31:0] ctrl, input logic r, input logic q,
                       input logic [4:0] n, input logic [4:0] y, input logic [31:0] p);
    @(posedge clk_in);
    run <= 1'b0;
    rep <= r;
    qrss <= q;
    tn <= n;
    ty <= y;
    pat <= p;
    @(posedge clk_in);
    run <= 1'b1;
    axw(OFS_TAPS, {19'h0, y, 3'h0, n});
    axw(OFS_PATTERN, p);
    axw(OFS_CTRL, ctrl);
    rd_chk(OFS_TAPS, {19'h0, y, 3'h0, n}, RESP_OKAY);
    rd_chk(OFS_PATTERN, p, RESP_OKAY);
    rd_chk(OFS_CTRL, ctrl & 32'h0000000F, RESP_OKAY);
    @(posedge clk_in);
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    #400000;
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    nrst_in = 1'b0;
    req = '0;
    lfsr_r = 32'h5F8E;
    {run, rep, qrss, gap, gap_en, flip} = 6'h0;
    {tn, ty, pat, dly_d, dly_q} = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1;
    chk1(sync_lost_flag_out, 1'b1);
    chk1(bert_active_out, 1'b0);
    rd_chk(OFS_STATUS, status_exp(1'b1, ST_HUNT, 1'b0), RESP_OKAY);
    rd_chk(8'h20, 32'h0, RESP_SLVERR);
    wr_chk(OFS_ERR_CNT, 32'h00000055, RESP_OKAY);
    wr_chk(8'h20, 32'h00000001, RESP_SLVERR);
    rd_chk(OFS_ERR_CNT, 32'h0, RESP_OKAY);
    gap_en <= 1'b1;
    start(32'h0, 1'b0, 1'b0, 5'h08, 5'h04, 32'h0);
    fwd_chk();
    // Pseudo-random lengths and QRSS, with random gaps in the stream
    for (int i = 0; i < 4; i++) begin
      start(i == 3 ? 32'h3 : 32'h1, 1'b0, i == 3, tn_tab[i], ty_tab[i], 32'h0);
      chk1(bert_active_out, 1'b1);
      chk1(fwd_data_out, 1'b1);
      chk1(fwd_qual_out, 1'b0);
      wait_flag(1'b0);
      rd_chk(OFS_STATUS, status_exp(1'b0, ST_SYNC, 1'b1), RESP_OKAY);
      repeat (300) @(posedge clk_in);
      rd_chk(OFS_ERR_CNT, 32'h0, RESP_OKAY);
      axr(OFS_BIT_CNT);
      chk1(rd !== 32'h0, 1'b1);
      axw(OFS_CTRL, 32'h0);
      rd_chk(OFS_STATUS, status_exp(1'b1, ST_HUNT, 1'b0), RESP_OKAY);
      fwd_chk();
    end
    // Mismatch window: five errors tolerated, six force a new search
    gap_en <= 1'b0;
    start(32'h1, 1'b0, 1'b0, 5'h0E, 5'h0D, 32'h0);
    wait_flag(1'b0);
    flip_bits(5);
    repeat (100) @(posedge clk_in);
    #1;
    chk1(sync_lost_flag_out, 1'b0);
    rd_chk(OFS_ERR_CNT, 32'h5, RESP_OKAY);
    axw(OFS_CTRL, 32'h11);
    rd_chk(OFS_ERR_CNT, 32'h0, RESP_OKAY);
    axw(OFS_CTRL, 32'h0);
    axw(OFS_CTRL, 32'h1);
    wait_flag(1'b0);
    flip_bits(6);
    wait_flag(1'b1);
    wait_flag(1'b0);
    axw(OFS_CTRL, 32'h0);
    axw(OFS_CTRL, 32'h9);
    wait_flag(1'b0);
    flip_bits(6);
    repeat (150) @(posedge clk_in);
    #1;
    chk1(sync_lost_flag_out, 1'b0);
    // Six errors before the resync plus six with resync disabled
    rd_chk(OFS_ERR_CNT, 32'h0000000C, RESP_OKAY);
    axw(OFS_CTRL, 32'h0);
    // Repetitive patterns at both length limits and in between
    for (int i = 0; i < 3; i++) begin
      gap_en <= 1'b1;
      start(32'h5, 1'b1, 1'b0, 5'(len_tab[i] - 1), 5'h0, lfsr_r & mask_of(len_tab[i]));
      wait_flag(1'b0);
      rd_chk(OFS_STATUS, status_exp(1'b0, ST_SYNC, 1'b1), RESP_OKAY);
      gap_en <= 1'b0;
      repeat (4) @(posedge clk_in);
      flip_bits(6);
      wait_flag(1'b1);
      wait_flag(1'b0);
      axw(OFS_CTRL, 32'h0);
    end
    // Clear while disabled; nothing may count out of sync
    axw(OFS_CTRL, 32'h10);
    repeat (100) @(posedge clk_in);
    rd_chk(OFS_BIT_CNT, 32'h0, RESP_OKAY);
    rd_chk(OFS_ERR_CNT, 32'h0, RESP_OKAY);
    finish_test();
  end
endmodule // bert_receive_pattern_sync_bench

`default_nettype wire
